// >>> src/spp_port.sv
// Purpose: Six-pin port with pulls, open drain, change flag, alt functions
// Assumes: Pads resolved outside from pad_o and pad_oe_o
// Notes:   Operation
// Operation
// RQ1 - Six pins, data and direction registers
// RQ2 - Pull-high per pin, none on pin 3
// RQ3 - Pull-low bits 7:4 for pins 3:0
// RQ4 - Open-drain per pin, pin 3 always
// RQ5 - Read returns pad or latch per pin
// RQ6 - Selected pin change sets change flag
// RQ7 - Irq needs flag, enable and global enable
// RQ8 - Select bit also enables wake-up
// RQ9 - Pin 0 external interrupt when selected
// RQ10 - External interrupt on chosen edge
// RQ11 - External interrupt masks pin 0 change
// RQ12 - IR carrier driven onto pin 1
// RQ13 - Pin 3 low requests reset when optioned
// RQ14 - Instruction clock on pin 4 optioned; code drives it only in normal and standby modes
// RQ15 - Pin 2 timer0 clock when selected
// RQ16 - Pin 2 timer1 clock when selected
// RQ17 - Pin 2 drives pwm or buzzer
// RQ18 - IR enable forces pin 1 output
// RQ19 - Pwm enable forces pin 2 output
// RQ20 - Change flag held until written zero
// RQ21 - Change compares level with previous sample
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module spp_port
  import spp_pkg::*;
#(
  parameter logic [7:0] INST_DIV = spp_pkg::SPP_INST_DIV
) (
  // Clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  // Register port
  input  wire logic [spp_pkg::SPP_AW-1:0] addr_i,
  input  wire logic [spp_pkg::SPP_DW-1:0] wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [spp_pkg::SPP_DW-1:0] rdata_o,
  // Pads
  input  wire logic [5:0]                 pad_i,
  output logic      [5:0]                 pad_o,
  output logic      [5:0]                 pad_oe_o,
  output logic      [5:0]                 pullhigh_en_o,
  output logic      [5:0]                 pulllow_en_o,
  // Configuration and mode
  input  wire logic                       reset_pad_enable_i,
  input  wire logic                       inst_clk_out_enable_i,
  input  wire logic                       pb2_buzzer_sel_i,
  input  wire logic [1:0]                 op_mode_i,
  // Alternate function sources
  input  wire logic                       ir_carrier_i,
  input  wire logic                       pwm1_i,
  input  wire logic                       buzzer1_i,
  // Events and alternate function sinks
  output logic                            ext_int_signal_o,
  output logic                            wakeup_flag_set_o,
  output logic                            level_change_irq_o,
  output logic                            reset_request_o,
  output logic                            timer0_ext_clk_o,
  output logic                            timer1_ext_clk_o,
  output logic                            inst_clk_o
);
  import spp_pkg::*;

  spp_state_t state_reg;
  spp_state_t state_next;
  logic [5:0] change;
  logic [5:0] val;
  logic [5:0] drv;
  logic [5:0] odm;
  logic [5:0] rd_pins;
  logic       edge_hit;

  always_comb begin
    state_next = state_reg;
    change = SPP_ZERO6;
    val = SPP_ZERO6;
    drv = SPP_ZERO6;
    odm = SPP_ZERO6;
    rd_pins = SPP_ZERO6;
    edge_hit = 1'b0;
    // Three-stage synchroniser, change taken when stages two and three agree
    state_next.sync1 = pad_i;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    state_next.level = (~(state_reg.sync2 ^ state_reg.sync3) & state_reg.sync3)
                     | ((state_reg.sync2 ^ state_reg.sync3) & state_reg.level);
    // Instruction clock divider
    state_next.ien = 1'b0;
    if (state_reg.div >= INST_DIV - 8'h01) begin
      state_next.div = 8'h00;
      state_next.ien = 1'b1;
      state_next.iclk = ~state_reg.iclk;
    end else begin
      state_next.div = state_reg.div + 8'h01;
    end
    // Sample on every instruction clock edge
    if (state_reg.ien) begin
      state_next.prev = state_reg.level;
      change = (state_reg.level ^ state_reg.prev) & state_reg.lcs; // RQ21 RQ6
      if (state_reg.ext_int_select) begin
        change[0] = 1'b0; // RQ11
      end
    end
    state_next.wake = |change; // RQ8
    // External interrupt edge on pin 0
    state_next.lvl0_d = state_reg.level[0];
    edge_hit = state_reg.edge_sel ? (state_reg.level[0] & ~state_reg.lvl0_d)
                                  : (~state_reg.level[0] & state_reg.lvl0_d); // RQ10
    state_next.ext_int = state_reg.ext_int_select & edge_hit; // RQ9
    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        SPP_PIN_DATA_REG_ADDR: state_next.data = wdata_i[5:0]; // RQ1
        SPP_PIN_DIRECTION_REG_ADDR: state_next.dir = wdata_i[5:0]; // RQ1
        SPP_PULLHIGH_ENABLE_REG_ADDR: state_next.ph = wdata_i[5:0];
        SPP_PULLLOW_ENABLE_REG_ADDR: state_next.pl = wdata_i[SPP_PL_LSB+3:SPP_PL_LSB];
        SPP_OPENDRAIN_ENABLE_REG_ADDR: state_next.od = wdata_i[5:0];
        SPP_LEVEL_CHANGE_SELECT_REG_ADDR: state_next.lcs = wdata_i[5:0];
        SPP_READ_TYPE_REG_ADDR: state_next.rdt = wdata_i[5:0];
        SPP_INT_FLAG_REG_ADDR: state_next.lcf = state_reg.lcf & wdata_i[SPP_LCF_BIT];
        SPP_INT_ENABLE_REG_ADDR: state_next.lcie = wdata_i[SPP_LCIE_BIT];
        SPP_POWER_CONTROL_REG_ADDR: state_next.ext_int_select = wdata_i[SPP_EIS_BIT];
        SPP_POWER_CONTROL_REG1_ADDR: state_next.global_int_enable = wdata_i[SPP_GIE_BIT];
        SPP_IR_CONTROL_REG_ADDR: begin
          state_next.ir_carrier_enable = wdata_i[SPP_IR_CARRIER_ENABLE_BIT];
          state_next.irf = wdata_i[SPP_IRF_BIT];
          state_next.irpol = wdata_i[SPP_IRPOL_BIT];
        end
        SPP_TIMER0_MODE_REG_ADDR: begin
          state_next.timer0_clock_source = wdata_i[SPP_TIMER0_CLOCK_SOURCE_BIT];
          state_next.t0lck = wdata_i[SPP_T0LCK_BIT];
        end
        SPP_TIMER1_CONTROL_REG1_ADDR: state_next.pwm_en = wdata_i[SPP_PWM_BIT];
        SPP_TIMER1_CONTROL_REG2_ADDR: state_next.timer1_clock_source = wdata_i[SPP_TIMER1_CLOCK_SOURCE_BIT];
        SPP_BUZZER1_CONTROL_REG_ADDR: state_next.bz_en = wdata_i[SPP_BZ_BIT];
        SPP_EXT_INT_EDGE_REG_ADDR: state_next.edge_sel = wdata_i[SPP_EDGE_BIT];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (|change) begin
      state_next.lcf = 1'b1; // RQ6 RQ20
    end
    // Register reads, answer in the next cycle only
    rd_pins = (state_reg.rdt & state_reg.data) | (~state_reg.rdt & state_reg.level); // RQ5
    state_next.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        SPP_PIN_DATA_REG_ADDR: state_next.rdata = {2'b00, rd_pins};
        SPP_PIN_DIRECTION_REG_ADDR: state_next.rdata = {2'b00, state_reg.dir};
        SPP_PULLHIGH_ENABLE_REG_ADDR: state_next.rdata = {2'b00, state_reg.ph};
        SPP_PULLLOW_ENABLE_REG_ADDR: state_next.rdata = {state_reg.pl, 4'h0};
        SPP_OPENDRAIN_ENABLE_REG_ADDR: state_next.rdata = {2'b00, state_reg.od};
        SPP_LEVEL_CHANGE_SELECT_REG_ADDR: state_next.rdata = {2'b00, state_reg.lcs};
        SPP_READ_TYPE_REG_ADDR: state_next.rdata = {2'b00, state_reg.rdt};
        SPP_INT_FLAG_REG_ADDR: state_next.rdata[SPP_LCF_BIT] = state_reg.lcf;
        SPP_INT_ENABLE_REG_ADDR: state_next.rdata[SPP_LCIE_BIT] = state_reg.lcie;
        SPP_POWER_CONTROL_REG_ADDR: state_next.rdata[SPP_EIS_BIT] = state_reg.ext_int_select;
        SPP_POWER_CONTROL_REG1_ADDR: state_next.rdata[SPP_GIE_BIT] = state_reg.global_int_enable;
        SPP_IR_CONTROL_REG_ADDR: state_next.rdata = {5'h00, state_reg.irpol,
                                                     state_reg.irf, state_reg.ir_carrier_enable};
        SPP_TIMER0_MODE_REG_ADDR: begin
          state_next.rdata[SPP_TIMER0_CLOCK_SOURCE_BIT] = state_reg.timer0_clock_source;
          state_next.rdata[SPP_T0LCK_BIT] = state_reg.t0lck;
        end
        SPP_TIMER1_CONTROL_REG1_ADDR: state_next.rdata[SPP_PWM_BIT] = state_reg.pwm_en;
        SPP_TIMER1_CONTROL_REG2_ADDR: state_next.rdata[SPP_TIMER1_CLOCK_SOURCE_BIT] = state_reg.timer1_clock_source;
        SPP_BUZZER1_CONTROL_REG_ADDR: state_next.rdata[SPP_BZ_BIT] = state_reg.bz_en;
        SPP_EXT_INT_EDGE_REG_ADDR: state_next.rdata[SPP_EDGE_BIT] = state_reg.edge_sel;
        default: state_next.rdata = 8'h00;
      endcase
    end
    // Pin multiplexing, general purpose first
    val = state_reg.data;
    drv = ~state_reg.dir; // RQ1
    odm = state_reg.od; // RQ4
    odm[3] = 1'b1; // RQ4
    // Alternate functions drive push-pull
    if (state_reg.ir_carrier_enable) begin
      val[1] = ir_carrier_i & (state_reg.data[1] ^ state_reg.irpol); // RQ12
      drv[1] = 1'b1; // RQ18
      odm[1] = 1'b0;
    end
    if (state_reg.pwm_en && !pb2_buzzer_sel_i) begin
      val[2] = pwm1_i; // RQ17
      drv[2] = 1'b1; // RQ19
      odm[2] = 1'b0;
    end else if (state_reg.bz_en && pb2_buzzer_sel_i) begin
      val[2] = buzzer1_i; // RQ17
      drv[2] = 1'b1;
      odm[2] = 1'b0;
    end
    if (reset_pad_enable_i) begin
      drv[3] = 1'b0; // RQ13
    end
    if (inst_clk_out_enable_i &&
        (op_mode_i == SPP_MODE_NORMAL || op_mode_i == SPP_MODE_STANDBY)) begin
      val[4] = state_reg.iclk; // RQ14
      drv[4] = 1'b1;
      odm[4] = 1'b0;
    end
    state_next.pad = val;
    state_next.oe = drv & ~(odm & val); // RQ4
    state_next.phe = state_reg.ph & ~drv & SPP_PH_MASK; // RQ2
    state_next.ple = {2'b00, state_reg.pl} & ~drv & SPP_PL_MASK; // RQ3
    state_next.irq = state_reg.lcf & state_reg.lcie & state_reg.global_int_enable; // RQ7
    state_next.rst_req = reset_pad_enable_i & ~state_reg.level[3]; // RQ13
    state_next.t0clk = state_reg.timer0_clock_source & ~state_reg.t0lck & state_reg.level[2]; // RQ15
    state_next.t1clk = state_reg.timer1_clock_source & state_reg.level[2]; // RQ16
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.dir <= SPP_DIR_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign pad_o = state_reg.pad;
  assign pad_oe_o = state_reg.oe;
  assign pullhigh_en_o = state_reg.phe;
  assign pulllow_en_o = state_reg.ple;
  assign ext_int_signal_o = state_reg.ext_int;
  assign wakeup_flag_set_o = state_reg.wake;
  assign level_change_irq_o = state_reg.irq;
  assign reset_request_o = state_reg.rst_req;
  assign timer0_ext_clk_o = state_reg.t0clk;
  assign timer1_ext_clk_o = state_reg.t1clk;
  assign inst_clk_o = state_reg.iclk;

  // Checks
  sequence s_change;
    state_reg.ien && !state_reg.ext_int_select &&
      (|((state_reg.level ^ state_reg.prev) & state_reg.lcs));
  endsequence

  sequence s_no_clear;
    state_reg.lcf && !(wr_i && addr_i == SPP_INT_FLAG_REG_ADDR);
  endsequence

  property p_dir_out;
    @(posedge clk_sys_i) disable iff (rst_i)
      pad_oe_o[0] |-> !$past(state_reg.dir[0]);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("pin 0 driven as input"); // RQ1

  property p_no_ph3;
    @(posedge clk_sys_i) disable iff (rst_i) !pullhigh_en_o[3];
  endproperty
  a_no_ph3: assert property (p_no_ph3) else $error("pull-high on pin 3"); // RQ2

  property p_no_pl54;
    @(posedge clk_sys_i) disable iff (rst_i) pulllow_en_o[5:4] == 2'b00;
  endproperty
  a_no_pl54: assert property (p_no_pl54) else $error("pull-low on pin 4 or 5"); // RQ3

  property p_od3;
    @(posedge clk_sys_i) disable iff (rst_i) pad_oe_o[3] |-> !pad_o[3];
  endproperty
  a_od3: assert property (p_od3) else $error("pin 3 driven high"); // RQ4

  property p_flag_set;
    @(posedge clk_sys_i) disable iff (rst_i) s_change |=> state_reg.lcf;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("change flag not set"); // RQ6

  property p_wake;
    @(posedge clk_sys_i) disable iff (rst_i) s_change |=> wakeup_flag_set_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up not flagged"); // RQ8

  property p_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
      level_change_irq_o |-> $past(state_reg.lcf && state_reg.lcie && state_reg.global_int_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause"); // RQ7

  property p_ext_mask;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg.ien && state_reg.ext_int_select && !state_reg.lcf &&
       ((state_reg.level ^ state_reg.prev) & state_reg.lcs) == 6'h01) |=> !state_reg.lcf;
  endproperty
  a_ext_mask: assert property (p_ext_mask) else $error("pin 0 change not masked"); // RQ11

  property p_hold;
    @(posedge clk_sys_i) disable iff (rst_i) s_no_clear |=> state_reg.lcf;
  endproperty
  a_hold: assert property (p_hold) else $error("change flag dropped"); // RQ20

  property p_ext_int;
    @(posedge clk_sys_i) disable iff (rst_i) ext_int_signal_o |-> $past(state_reg.ext_int_select);
  endproperty
  a_ext_int: assert property (p_ext_int) else $error("external interrupt while off"); // RQ9

  property p_ir_out;
    @(posedge clk_sys_i) disable iff (rst_i) state_reg.ir_carrier_enable |=> pad_oe_o[1];
  endproperty
  a_ir_out: assert property (p_ir_out) else $error("pin 1 not forced out"); // RQ18

  property p_pwm_out;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg.pwm_en && !pb2_buzzer_sel_i) |=> pad_oe_o[2];
  endproperty
  a_pwm_out: assert property (p_pwm_out) else $error("pin 2 not forced out"); // RQ19

  property p_rst_pad;
    @(posedge clk_sys_i) disable iff (rst_i)
      reset_request_o |-> $past(reset_pad_enable_i && !state_reg.level[3]);
  endproperty
  a_rst_pad: assert property (p_rst_pad) else $error("reset request without cause"); // RQ13

  property p_ext_edge;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg.ext_int_select && (state_reg.edge_sel ? $rose(state_reg.level[0])
                                            : $fell(state_reg.level[0]))) |=> ext_int_signal_o;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin 0 edge missed"); // RQ10

  property p_ir_val;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_reg.ir_carrier_enable |=>
        pad_o[1] == $past(ir_carrier_i & (state_reg.data[1] ^ state_reg.irpol));
  endproperty
  a_ir_val: assert property (p_ir_val) else $error("pin 1 carrier wrong"); // RQ12

  property p_iclk_pin;
    @(posedge clk_sys_i) disable iff (rst_i)
      (inst_clk_out_enable_i && (op_mode_i == SPP_MODE_NORMAL || op_mode_i == SPP_MODE_STANDBY))
        |=> pad_oe_o[4] && pad_o[4] == $past(state_reg.iclk);
  endproperty
  a_iclk_pin: assert property (p_iclk_pin) else $error("pin 4 clock missing"); // RQ14

  property p_t0clk;
    @(posedge clk_sys_i) disable iff (rst_i)
      timer0_ext_clk_o |-> $past(state_reg.timer0_clock_source && !state_reg.t0lck && state_reg.level[2]);
  endproperty
  a_t0clk: assert property (p_t0clk) else $error("timer0 clock without cause"); // RQ15

  property p_t1clk;
    @(posedge clk_sys_i) disable iff (rst_i)
      timer1_ext_clk_o |-> $past(state_reg.timer1_clock_source && state_reg.level[2]);
  endproperty
  a_t1clk: assert property (p_t1clk) else $error("timer1 clock without cause"); // RQ16

  property p_tick;
    @(posedge clk_sys_i) disable iff (rst_i) wakeup_flag_set_o |-> $past(state_reg.ien);
  endproperty
  a_tick: assert property (p_tick) else $error("change seen off tick"); // RQ21
endmodule : spp_port
`default_nettype wire

// >>> src/spp_pkg.sv
// Purpose: Constants and state carrier for the six-pin port
// Assumes: 8-bit register port, 5-bit address
// Notes:   Direction bit 1 means input
package spp_pkg;
  localparam int  SPP_PINS = 6;
  localparam int  SPP_AW   = 5;
  localparam int  SPP_DW   = 8;
  localparam int  SPP_DIVW = 8;
  // Register addresses
  localparam logic [4:0] SPP_PIN_DATA_REG_ADDR       = 5'h00;
  localparam logic [4:0] SPP_PIN_DIRECTION_REG_ADDR  = 5'h01;
  localparam logic [4:0] SPP_PULLHIGH_ENABLE_REG_ADDR = 5'h02;
  localparam logic [4:0] SPP_PULLLOW_ENABLE_REG_ADDR = 5'h03;
  localparam logic [4:0] SPP_OPENDRAIN_ENABLE_REG_ADDR = 5'h04;
  localparam logic [4:0] SPP_LEVEL_CHANGE_SELECT_REG_ADDR = 5'h05;
  localparam logic [4:0] SPP_READ_TYPE_REG_ADDR      = 5'h06;
  localparam logic [4:0] SPP_INT_FLAG_REG_ADDR       = 5'h07;
  localparam logic [4:0] SPP_INT_ENABLE_REG_ADDR     = 5'h08;
  localparam logic [4:0] SPP_POWER_CONTROL_REG_ADDR  = 5'h09;
  localparam logic [4:0] SPP_POWER_CONTROL_REG1_ADDR = 5'h0a;
  localparam logic [4:0] SPP_IR_CONTROL_REG_ADDR     = 5'h0b;
  localparam logic [4:0] SPP_TIMER0_MODE_REG_ADDR    = 5'h0c;
  localparam logic [4:0] SPP_TIMER1_CONTROL_REG1_ADDR = 5'h0d;
  localparam logic [4:0] SPP_TIMER1_CONTROL_REG2_ADDR = 5'h0e;
  localparam logic [4:0] SPP_BUZZER1_CONTROL_REG_ADDR = 5'h0f;
  localparam logic [4:0] SPP_EXT_INT_EDGE_REG_ADDR   = 5'h10;
  // Field positions
  localparam int SPP_LCF_BIT    = 1;
  localparam int SPP_LCIE_BIT   = 1;
  localparam int SPP_EIS_BIT    = 6;
  localparam int SPP_GIE_BIT    = 7;
  localparam int SPP_IR_CARRIER_ENABLE_BIT   = 0;
  localparam int SPP_IRF_BIT    = 1;
  localparam int SPP_IRPOL_BIT  = 2;
  localparam int SPP_TIMER0_CLOCK_SOURCE_BIT   = 5;
  localparam int SPP_T0LCK_BIT  = 7;
  localparam int SPP_PWM_BIT    = 7;
  localparam int SPP_TIMER1_CLOCK_SOURCE_BIT   = 5;
  localparam int SPP_BZ_BIT     = 7;
  localparam int SPP_EDGE_BIT   = 0;
  localparam int SPP_PL_LSB     = 4;
  // Pin capability masks
  localparam logic [5:0] SPP_PH_MASK = 6'h37;
  localparam logic [5:0] SPP_PL_MASK = 6'h0f;
  // Reset values, mode codes and divider default
  localparam logic [5:0] SPP_DIR_RST = 6'h3f;
  localparam logic [5:0] SPP_ZERO6   = 6'h00;
  localparam logic [1:0] SPP_MODE_NORMAL  = 2'h0;
  localparam logic [1:0] SPP_MODE_STANDBY = 2'h2;
  localparam logic [7:0] SPP_INST_DIV = 8'h02;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] level;
    logic [5:0] prev;
    logic       lvl0_d;
    logic [5:0] data;
    logic [5:0] dir;
    logic [5:0] ph;
    logic [3:0] pl;
    logic [5:0] od;
    logic [5:0] lcs;
    logic [5:0] rdt;
    logic       lcf;
    logic       lcie;
    logic       ext_int_select;
    logic       edge_sel;
    logic       global_int_enable;
    logic       ir_carrier_enable;
    logic       irf;
    logic       irpol;
    logic       timer0_clock_source;
    logic       t0lck;
    logic       timer1_clock_source;
    logic       pwm_en;
    logic       bz_en;
    logic [7:0] rdata;
    logic [5:0] pad;
    logic [5:0] oe;
    logic [5:0] phe;
    logic [5:0] ple;
    logic       ext_int;
    logic       wake;
    logic       irq;
    logic       rst_req;
    logic       t0clk;
    logic       t1clk;
    logic [7:0] div;
    logic       iclk;
    logic       ien;
  } spp_state_t;
endpackage : spp_pkg

// >>> tb/spp_pad_model.sv
// Purpose: Board and pad model for the six-pin port
// Assumes: Bench drives a pad only where ext_en_i is set
// Notes:   Unpulled floating pads toggle so no stale level survives
`timescale 1ns/100ps
`default_nettype none
module spp_pad_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Device side
  input  wire logic [5:0] pad_o,
  input  wire logic [5:0] pad_oe_o,
  input  wire logic [5:0] pullhigh_en_o,
  input  wire logic [5:0] pulllow_en_o,
  // Board side
  input  wire logic [5:0] ext_en_i,
  input  wire logic [5:0] ext_val_i,
  output logic      [5:0] pad_level_o
);
  logic [5:0] float_reg = 6'h00;

  always @(posedge clk_sys_i) begin
    float_reg <= ~float_reg;
  end

  // Device drive wins over the board
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_oe_o[i]) pad_level_o[i] = pad_o[i];
      else if (ext_en_i[i]) pad_level_o[i] = ext_val_i[i];
      else if (pullhigh_en_o[i]) pad_level_o[i] = 1'b1;
      else if (pulllow_en_o[i]) pad_level_o[i] = 1'b0;
      else pad_level_o[i] = float_reg[i];
    end
  end
endmodule : spp_pad_model
`default_nettype wire

// >>> tb/spp_port_tb_top.sv
// Purpose: Self-checking bench for the six-pin port
// Assumes: INST_DIV of 2, pads resolved by the pad model
// Notes:   Register image held in mreg, compared at every chkreg read
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module spp_port_tb_top;
  import spp_pkg::*;
  logic       clk, rst, wr, rd, rpe, ice, bzsel, irc, pwm, bz;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [5:0] pad_lvl, pad_o, pad_oe, ph, pl, ext_en, ext_val, r6, q6, eo;
  logic [1:0] mode;
  logic       ext_int, wake, irq, rreq, t0c, t1c, iclk;
  int         error_cnt, n_compared, wk_cnt, ei_cnt, tog, tci;
  int         mreg[32];

  spp_port #(.INST_DIV(8'h02)) dut (
    .clk_sys_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .pad_i(pad_lvl), .pad_o(pad_o), .pad_oe_o(pad_oe),
    .pullhigh_en_o(ph), .pulllow_en_o(pl), .reset_pad_enable_i(rpe),
    .inst_clk_out_enable_i(ice), .pb2_buzzer_sel_i(bzsel), .op_mode_i(mode),
    .ir_carrier_i(irc), .pwm1_i(pwm), .buzzer1_i(bz), .ext_int_signal_o(ext_int),
    .wakeup_flag_set_o(wake), .level_change_irq_o(irq), .reset_request_o(rreq),
    .timer0_ext_clk_o(t0c), .timer1_ext_clk_o(t1c), .inst_clk_o(iclk));

  spp_pad_model pads (
    .clk_sys_i(clk), .pad_o(pad_o), .pad_oe_o(pad_oe), .pullhigh_en_o(ph),
    .pulllow_en_o(pl), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_level_o(pad_lvl));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wake === 1'b1) wk_cnt++;
    if (ext_int === 1'b1) ei_cnt++;
  end

  task automatic complete_run;
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a <= 5'h10) mreg[a] = int'(d & (a == 5'h03 ? 8'hf0 : 8'h3f));
  endtask : wreg

  task automatic rreg(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task automatic chkreg(input logic [4:0] a);
    rreg(a, rv);
    `CHK("reg", mreg[a][7:0], rv)
  endtask : chkreg

  // Long enough for sync, tick and flag to land
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    ext_val[i] <= v;
    cyc(10);
  endtask : pin

  initial begin
    #(25 * 20000);
    error_cnt++;
    complete_run();
  end

  initial begin
    {rst, wr, rd, rpe, ice, bzsel, irc, pwm, bz} = 9'h100;
    {addr, wdata, mode, ext_val, ext_en} = {5'h00, 8'h00, 2'h0, 6'h00, 6'h3f};
    {error_cnt, n_compared, wk_cnt, ei_cnt} = '0;
    foreach (mreg[i]) mreg[i] = 0;
    mreg[1] = 32'h3f;
    void'($urandom(32'h0c91));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) chkreg(a[4:0]);
    wreg(5'h1f, 8'hff);
    chkreg(5'h01);
    rreg(5'h1f, rv);
    `CHK("unmapped", 8'h00, rv)
    for (int k = 0; k < 4; k++) begin
      r6 = 6'($urandom);
      q6 = 6'($urandom);
      wreg(5'h00, {2'b00, r6});
      wreg(5'h01, {2'b00, q6});
      wreg(5'h04, k[0] ? 8'h3f : 8'h00);
      cyc(3);
      eo = ~q6 & ~(((k[0] ? 6'h3f : 6'h00) | 6'h08) & r6);
      `CHK("oe", eo, pad_oe)
      `CHK("out", r6 & eo, pad_o & eo)
      chkreg(5'h01);
    end
    wreg(5'h01, 8'h3f);
    r6 = 6'($urandom);
    @(posedge clk) ext_en <= 6'h00;
    wreg(5'h02, {2'b00, r6});
    wreg(5'h03, {r6[3:0], 4'h0});
    cyc(3);
    `CHK("pullhigh", r6 & 6'h37, ph)
    `CHK("pulllow", {2'b00, r6[3:0]}, pl)
    chkreg(5'h03);
    @(posedge clk) ext_en <= 6'h3f;
    ext_val <= 6'h2a;
    wreg(5'h00, 8'h15);
    wreg(5'h06, 8'h00);
    cyc(6);
    rreg(5'h00, rv);
    `CHK("pad read", 8'h2a, rv)
    wreg(5'h06, 8'h3f);
    rreg(5'h00, rv);
    `CHK("latch read", 8'h15, rv)
    @(posedge clk) ext_val <= 6'h00;
    cyc(8);
    wreg(5'h05, 8'h3f);
    wreg(5'h09, 8'h40);
    wreg(5'h08, 8'h02);
    wreg(5'h0a, 8'h80);
    for (int e = 0; e < 2; e++) begin
      wreg(5'h10, e[7:0]);
      pin(0, 1'b1);
      pin(0, 1'b0);
      `CHK("ext int", e + 1, ei_cnt)
    end
    `CHK("pin0 change", 0, wk_cnt)
    pin(2, 1'b1);
    `CHK("wake", 1, wk_cnt)
    `CHK("irq on", 1'b1, irq)
    rreg(5'h07, rv);
    `CHK("flag set", 8'h02, rv & 8'h02)
    wreg(5'h07, 8'h02);
    rreg(5'h07, rv);
    `CHK("flag held", 8'h02, rv & 8'h02)
    wreg(5'h0a, 8'h00);
    cyc(3);
    `CHK("irq gated", 1'b0, irq)
    wreg(5'h07, 8'h00);
    wreg(5'h05, 8'h3b);
    pin(2, 1'b0);
    rreg(5'h07, rv);
    `CHK("flag unselected", 8'h00, rv & 8'h02)
    wreg(5'h00, 8'h02);
    @(posedge clk) irc <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wreg(5'h0b, {5'h00, p[0], 2'b01});
      cyc(3);
      `CHK("ir oe", 1'b1, pad_oe[1])
      `CHK("ir out", ~p[0], pad_o[1])
    end
    wreg(5'h0b, 8'h00);
    cyc(3);
    `CHK("ir off", 1'b0, pad_oe[1])
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) {bzsel, pwm, bz} <= {s[0], ~s[0], s[0]};
      wreg(5'h0d, s[0] ? 8'h00 : 8'h80);
      wreg(5'h0f, s[0] ? 8'h80 : 8'h00);
      cyc(3);
      `CHK("pb2 oe", 1'b1, pad_oe[2])
      `CHK("pb2 out", 1'b1, pad_o[2])
    end
    wreg(5'h0f, 8'h00);
    pin(2, 1'b1);
    wreg(5'h0c, 8'h20);
    wreg(5'h0e, 8'h20);
    cyc(3);
    `CHK("t0 clk", 1'b1, t0c)
    `CHK("t1 clk", 1'b1, t1c)
    wreg(5'h0c, 8'ha0);
    cyc(3);
    `CHK("t0 lowclk", 1'b0, t0c)
    @(posedge clk) rpe <= 1'b1;
    cyc(6);
    `CHK("rst req", 1'b1, rreq)
    pin(3, 1'b1);
    `CHK("rst idle", 1'b0, rreq)
    @(posedge clk) ice <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      @(posedge clk) mode <= m[1:0];
      cyc(4);
      tog = 0;
      tci = 0;
      repeat (16) begin
        rv[0] = pad_o[4];
        rv[1] = iclk;
        cyc(1);
        if (pad_o[4] !== rv[0]) tog++;
        if (iclk !== rv[1]) tci++;
      end
      `CHK("iclk free", 8, tci)
      `CHK("iclk oe", m != 1, pad_oe[4])
      if (m != 1) `CHK("iclk toggles", 8, tog)
    end
    complete_run();
  end
endmodule : spp_port_tb_top
`default_nettype wire
